// *** include/lhr_pkg.sv ***
package lhr_pkg;

    // Bus addresses selected by the address jumper pin.
    localparam logic [6:0] ADDR_PIN_LOW = 7'h56;
    localparam logic [6:0] ADDR_PIN_HIGH = 7'h57;

    // Register indices.
    localparam logic [7:0] REG_FIELD_CODE_LOW = 8'h00;
    localparam logic [7:0] REG_FIELD_CODE_HIGH_STATUS = 8'h01;
    localparam logic [7:0] REG_SENSOR_CONFIG = 8'h02;
    localparam logic [7:0] REG_RANGE_SELECT = 8'h0B;

    // Field positions.
    localparam int CFG_POWER_DOWN_BIT = 0;
    localparam int CFG_POLARITY_BIT = 1;
    localparam int CFG_FAST_MODE_BIT = 3;
    localparam int STS_DONE_BIT = 2;
    localparam int STS_PARITY_BIT = 3;

    // Values after reset.
    localparam logic [7:0] SENSOR_CONFIG_RESET = 8'h00;
    localparam logic [1:0] RANGE_SELECT_RESET = 2'h0;
    localparam logic [7:0] REG_POINTER_RESET = 8'h00;

    // Code arithmetic.
    localparam logic signed [27:0] CODE_GAIN = 28'sd511;
    localparam logic signed [27:0] CODE_OFFSET = 28'sd511;
    localparam logic signed [27:0] CODE_MAX = 28'sd1023;
    localparam logic [9:0] CODE_RESET = 10'h1FF;

    // Full-scale sensitivities in microtesla, indexed by range select.
    localparam logic signed [27:0] SENS_UT_R0 = 28'sd50000;
    localparam logic signed [27:0] SENS_UT_R1 = 28'sd25000;
    localparam logic signed [27:0] SENS_UT_R2 = 28'sd12500;
    localparam logic signed [27:0] SENS_UT_R3 = 28'sd18700;

    // Conversion periods.
    localparam int CLK_FREQ_HZ = 50_000_000;
    localparam int CONV_SLOW_US = 50;
    localparam int CONV_FAST_US = 10;
    localparam int CONV_SLOW_CYCLES = CONV_SLOW_US * (CLK_FREQ_HZ / 1_000_000);
    localparam int CONV_FAST_CYCLES = CONV_FAST_US * (CLK_FREQ_HZ / 1_000_000);
    localparam int CONV_CNT_W = 12;

    typedef enum logic [3:0] {
        LHR_IDLE = 4'b0000,
        LHR_ADDR = 4'b0001,
        LHR_ADDR_ACK = 4'b0010,
        LHR_POINTER = 4'b0011,
        LHR_POINTER_ACK = 4'b0100,
        LHR_WDATA = 4'b0101,
        LHR_WDATA_ACK = 4'b0110,
        LHR_RDATA = 4'b0111,
        LHR_HOST_ACK = 4'b1000
    } lhr_state_t;

endpackage

// *** core/lhr_field_conv.sv ***
`timescale 1ns/100ps
module lhr_field_conv (
    input wire logic clk,
    input wire logic reset,
    input wire logic sample,
    input wire logic signed [17:0] field_ut,
    input wire logic [1:0] range_sel,
    input wire logic polarity,
    output logic [9:0] code
);

    logic signed [27:0] field_ext;
    logic signed [27:0] scaled;
    logic signed [27:0] shifted;
    logic [9:0] next_code;

    always_comb
    begin
        field_ext = 28'(field_ut);
        if (polarity)
        begin
            field_ext = -field_ext;
        end
        scaled = field_ext * lhr_pkg::CODE_GAIN;
        case (range_sel)
            2'h0: scaled = scaled / lhr_pkg::SENS_UT_R0;
            2'h1: scaled = scaled / lhr_pkg::SENS_UT_R1;
            2'h2: scaled = scaled / lhr_pkg::SENS_UT_R2;
            default: scaled = scaled / lhr_pkg::SENS_UT_R3;
        endcase
        shifted = scaled + lhr_pkg::CODE_OFFSET;
        // Saturate instead of wrapping so an oversized field stays at a rail.
        if (shifted < 28'sd0)
        begin
            next_code = 10'h000;
        end
        else if (shifted > lhr_pkg::CODE_MAX)
        begin
            next_code = 10'h3FF;
        end
        else
        begin
            next_code = shifted[9:0];
        end
        if (!sample)
        begin
            next_code = code;
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            code <= lhr_pkg::CODE_RESET;
        end
        else
        begin
            code <= next_code;
        end
    end

endmodule

// *** core/lhr_readout.sv ***
// Functional notes
// - Answer 56h, or 57h with jumper high.
// - Code is field times 511/sensitivity plus 511.
// - Four ranges chosen by range_select.
// - Ranges 50, 25, 12.5, 18.7 mT.
// - Config bit 1 selects magnet polarity.
// - Config bit 3 selects slow or fast.
// - Config bit 0 powers the sensor down.
// - Registers 00h/01h return code, flag, parity.
// - Defaults: widest range, polarity zero.
// - Zero field gives 511, rails 0/1023.
`timescale 1ns/100ps
module lhr_readout (
    input wire logic clk,
    input wire logic reset,
    input wire logic scl,
    input wire logic sda_in,
    input wire logic addr_jumper,
    input wire logic signed [17:0] field_ut,
    output logic sda_out,
    output logic sda_oe,
    output logic power_down,
    output logic fast_mode
);

    function automatic logic even_parity(input logic [9:0] value);
        even_parity = ^value;
    endfunction

    // Two-flop synchronisers; logic reads the second stage and, for scl and sda, also a third flop for edges.
    logic scl_meta, scl_sync, scl_prev;
    logic sda_meta, sda_sync, sda_prev;
    logic adr_meta, adr_sync;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            scl_meta <= 1'b1;
            scl_sync <= 1'b1;
            scl_prev <= 1'b1;
            sda_meta <= 1'b1;
            sda_sync <= 1'b1;
            sda_prev <= 1'b1;
            adr_meta <= 1'b0;
            adr_sync <= 1'b0;
        end
        else
        begin
            scl_meta <= scl;
            scl_sync <= scl_meta;
            scl_prev <= scl_sync;
            sda_meta <= sda_in;
            sda_sync <= sda_meta;
            sda_prev <= sda_sync;
            adr_meta <= addr_jumper;
            adr_sync <= adr_meta;
        end
    end

    logic scl_rise, scl_fall, bus_start, bus_stop;
    logic [6:0] own_addr;

    assign scl_rise = scl_sync && !scl_prev;
    assign scl_fall = !scl_sync && scl_prev;
    assign bus_start = scl_sync && scl_prev && sda_prev && !sda_sync;
    assign bus_stop = scl_sync && scl_prev && !sda_prev && sda_sync;
    assign own_addr = adr_sync ? lhr_pkg::ADDR_PIN_HIGH
                               : lhr_pkg::ADDR_PIN_LOW;

    // Conversion sequencer and register file state.
    logic [7:0] sensor_config, next_sensor_config;
    logic [1:0] range_select, next_range_select;
    logic [lhr_pkg::CONV_CNT_W-1:0] conv_cnt, next_conv_cnt;
    logic conv_sample;
    logic done_flag, next_done_flag;
    logic [9:0] field_code;

    // Bus engine state.
    lhr_pkg::lhr_state_t state, next_state;
    logic [3:0] bit_cnt, next_bit_cnt;
    logic [7:0] shreg, next_shreg;
    logic [7:0] tx_byte, next_tx_byte;
    logic [7:0] reg_ptr, next_reg_ptr;
    logic read_mode, next_read_mode;
    logic host_nack, next_host_nack;
    logic next_sda_oe;
    logic wr_strobe;
    logic rd_status;

    function automatic logic [7:0] read_reg(
        input logic [7:0] index,
        input logic [9:0] value,
        input logic flag,
        input logic [7:0] cfg,
        input logic [1:0] rng
    );
        read_reg = 8'h00;
        if (index == lhr_pkg::REG_FIELD_CODE_LOW)
        begin
            read_reg = value[7:0];
        end
        else if (index == lhr_pkg::REG_FIELD_CODE_HIGH_STATUS)
        begin
            read_reg[1:0] = value[9:8];
            read_reg[lhr_pkg::STS_DONE_BIT] = flag;
            read_reg[lhr_pkg::STS_PARITY_BIT] = even_parity(value);
        end
        else if (index == lhr_pkg::REG_SENSOR_CONFIG)
        begin
            read_reg = cfg;
        end
        else if (index == lhr_pkg::REG_RANGE_SELECT)
        begin
            read_reg = {6'h00, rng};
        end
    endfunction

    always_comb
    begin
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_shreg = shreg;
        next_tx_byte = tx_byte;
        next_reg_ptr = reg_ptr;
        next_read_mode = read_mode;
        next_host_nack = host_nack;
        next_sda_oe = sda_oe;
        wr_strobe = 1'b0;
        rd_status = 1'b0;
        if (bus_start)
        begin
            next_state = lhr_pkg::LHR_ADDR;
            next_bit_cnt = 4'h0;
            next_sda_oe = 1'b0;
        end
        else if (bus_stop)
        begin
            next_state = lhr_pkg::LHR_IDLE;
            next_sda_oe = 1'b0;
        end
        else if (scl_rise)
        begin
            case (state)
                lhr_pkg::LHR_ADDR, lhr_pkg::LHR_POINTER,
                lhr_pkg::LHR_WDATA:
                begin
                    next_shreg = {shreg[6:0], sda_sync};
                    next_bit_cnt = bit_cnt + 4'h1;
                end
                lhr_pkg::LHR_RDATA:
                begin
                    next_bit_cnt = bit_cnt + 4'h1;
                end
                lhr_pkg::LHR_HOST_ACK:
                begin
                    next_host_nack = sda_sync;
                end
                default:
                begin
                end
            endcase
        end
        else if (scl_fall)
        begin
            case (state)
                lhr_pkg::LHR_ADDR:
                begin
                    if (bit_cnt == 4'h8)
                    begin
                        if (shreg[7:1] == own_addr)
                        begin
                            next_read_mode = shreg[0];
                            next_sda_oe = 1'b1;
                            next_state = lhr_pkg::LHR_ADDR_ACK;
                        end
                        else
                        begin
                            next_state = lhr_pkg::LHR_IDLE;
                        end
                    end
                end
                lhr_pkg::LHR_ADDR_ACK:
                begin
                    next_bit_cnt = 4'h0;
                    if (read_mode)
                    begin
                        next_tx_byte = read_reg(reg_ptr, field_code,
                                                done_flag, sensor_config,
                                                range_select);
                        rd_status = (reg_ptr ==
                            lhr_pkg::REG_FIELD_CODE_HIGH_STATUS);
                        next_sda_oe = !next_tx_byte[7];
                        next_state = lhr_pkg::LHR_RDATA;
                    end
                    else
                    begin
                        next_sda_oe = 1'b0;
                        next_state = lhr_pkg::LHR_POINTER;
                    end
                end
                lhr_pkg::LHR_POINTER:
                begin
                    if (bit_cnt == 4'h8)
                    begin
                        next_reg_ptr = shreg;
                        next_sda_oe = 1'b1;
                        next_state = lhr_pkg::LHR_POINTER_ACK;
                    end
                end
                lhr_pkg::LHR_POINTER_ACK, lhr_pkg::LHR_WDATA_ACK:
                begin
                    next_sda_oe = 1'b0;
                    next_bit_cnt = 4'h0;
                    next_state = lhr_pkg::LHR_WDATA;
                end
                lhr_pkg::LHR_WDATA:
                begin
                    if (bit_cnt == 4'h8)
                    begin
                        wr_strobe = 1'b1;
                        next_sda_oe = 1'b1;
                        next_state = lhr_pkg::LHR_WDATA_ACK;
                    end
                end
                lhr_pkg::LHR_RDATA:
                begin
                    if (bit_cnt == 4'h8)
                    begin
                        next_sda_oe = 1'b0;
                        next_state = lhr_pkg::LHR_HOST_ACK;
                    end
                    else
                    begin
                        next_tx_byte = {tx_byte[6:0], 1'b0};
                        next_sda_oe = !tx_byte[6];
                    end
                end
                lhr_pkg::LHR_HOST_ACK:
                begin
                    if (host_nack)
                    begin
                        next_state = lhr_pkg::LHR_IDLE;
                    end
                    else
                    begin
                        // Repeated reads return the same register.
                        next_state = lhr_pkg::LHR_ADDR_ACK;
                    end
                end
                default:
                begin
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            state <= lhr_pkg::LHR_IDLE;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            tx_byte <= 8'h00;
            reg_ptr <= lhr_pkg::REG_POINTER_RESET;
            read_mode <= 1'b0;
            host_nack <= 1'b0;
            sda_oe <= 1'b0;
        end
        else
        begin
            state <= next_state;
            bit_cnt <= next_bit_cnt;
            shreg <= next_shreg;
            tx_byte <= next_tx_byte;
            reg_ptr <= next_reg_ptr;
            read_mode <= next_read_mode;
            host_nack <= next_host_nack;
            sda_oe <= next_sda_oe;
        end
    end

    always_comb
    begin
        next_sensor_config = sensor_config;
        next_range_select = range_select;
        if (wr_strobe && reg_ptr == lhr_pkg::REG_SENSOR_CONFIG)
        begin
            next_sensor_config = shreg;
        end
        else if (wr_strobe && reg_ptr == lhr_pkg::REG_RANGE_SELECT)
        begin
            next_range_select = shreg[1:0];
        end
        next_conv_cnt = conv_cnt;
        conv_sample = 1'b0;
        if (sensor_config[lhr_pkg::CFG_POWER_DOWN_BIT])
        begin
            next_conv_cnt = '0;
        end
        else if (conv_cnt == '0)
        begin
            conv_sample = 1'b1;
            if (sensor_config[lhr_pkg::CFG_FAST_MODE_BIT])
            begin
                next_conv_cnt = lhr_pkg::CONV_CNT_W'(
                    lhr_pkg::CONV_FAST_CYCLES - 1);
            end
            else
            begin
                next_conv_cnt = lhr_pkg::CONV_CNT_W'(
                    lhr_pkg::CONV_SLOW_CYCLES - 1);
            end
        end
        else
        begin
            next_conv_cnt = conv_cnt - 1'b1;
        end
        // A fresh result in the same cycle as the status read keeps the flag.
        next_done_flag = done_flag;
        if (conv_sample)
        begin
            next_done_flag = 1'b1;
        end
        else if (rd_status)
        begin
            next_done_flag = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            sensor_config <= lhr_pkg::SENSOR_CONFIG_RESET;
            range_select <= lhr_pkg::RANGE_SELECT_RESET;
            conv_cnt <= '0;
            done_flag <= 1'b0;
            power_down <= 1'b0;
            fast_mode <= 1'b0;
            sda_out <= 1'b0;
        end
        else
        begin
            sensor_config <= next_sensor_config;
            range_select <= next_range_select;
            conv_cnt <= next_conv_cnt;
            done_flag <= next_done_flag;
            power_down <= next_sensor_config[lhr_pkg::CFG_POWER_DOWN_BIT];
            fast_mode <= next_sensor_config[lhr_pkg::CFG_FAST_MODE_BIT];
            sda_out <= 1'b0;
        end
    end

    // The result only moves on a sample, so a read never sees a torn code.
    lhr_field_conv u_conv (
        .clk(clk),
        .reset(reset),
        .sample(conv_sample),
        .field_ut(field_ut),
        .range_sel(range_select),
        .polarity(sensor_config[lhr_pkg::CFG_POLARITY_BIT]),
        .code(field_code)
    );

endmodule

// *** tb/lhr_readout_checker.sv ***
`timescale 1ns/100ps
module lhr_readout_checker (
    input wire logic clk,
    input wire logic reset,
    input wire logic scl,
    input wire logic sda_in,
    input wire logic addr_jumper,
    input wire logic signed [17:0] field_ut,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic power_down,
    input wire logic fast_mode
);
    logic scl_q;
    logic sda_q;
    logic busy;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic rise;
    logic start;
    logic stop;
    logic [6:0] own;
    assign rise = scl && !scl_q;
    assign start = scl && scl_q && sda_q && !sda_in;
    assign stop = scl && scl_q && !sda_q && sda_in;
    assign own = addr_jumper ? lhr_pkg::ADDR_PIN_HIGH : lhr_pkg::ADDR_PIN_LOW;
    // Only the address byte after each start is decoded; later bytes
    // would need the pointer state, which is left to the bench.
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            busy <= 1'b0;
            bitn <= 4'h0;
            sh <= 8'h00;
        end
        else
        begin
            scl_q <= scl;
            sda_q <= sda_in;
            busy <= start || (busy && !stop);
            if (start)
                bitn <= 4'h1;
            else if (rise && bitn != 4'h0 && bitn < 4'hA)
            begin
                bitn <= bitn + 4'h1;
                sh <= {sh[6:0], sda_in};
            end
        end
    end
    default clocking dc @(posedge clk); endclocking
    default disable iff (reset);
    property p_addr_ack;
        rise && bitn == 4'h9 |-> sda_oe == (sh[7:1] == own);
    endproperty
    a_addr_ack: assert property (p_addr_ack)
        else $error("address acknowledge wrong");
    property p_addr_quiet;
        bitn != 4'h0 && bitn < 4'h9 |-> !sda_oe;
    endproperty
    a_addr_quiet: assert property (p_addr_quiet)
        else $error("data line driven during address");
    property p_oe_late;
        $changed(sda_oe) |-> !$past(scl, 1) && !$past(scl, 2);
    endproperty
    a_oe_late: assert property (p_oe_late)
        else $error("data line changed too soon after clock fall");
    property p_oe_high;
        scl && scl_q |-> $stable(sda_oe);
    endproperty
    a_oe_high: assert property (p_oe_high)
        else $error("data line changed while clock high");
    property p_sda_low;
        sda_out == 1'b0;
    endproperty
    a_sda_low: assert property (p_sda_low)
        else $error("open drain value not low");
    property p_reset_vals;
        $fell(reset) |-> !sda_oe && !power_down && !fast_mode;
    endproperty
    a_reset_vals: assert property (p_reset_vals)
        else $error("outputs not at defaults after reset");
    property p_pd_xfer;
        $changed(power_down) |-> busy;
    endproperty
    a_pd_xfer: assert property (p_pd_xfer)
        else $error("power down changed outside a transfer");
    property p_fast_xfer;
        $changed(fast_mode) |-> busy;
    endproperty
    a_fast_xfer: assert property (p_fast_xfer)
        else $error("fast mode changed outside a transfer");
    c_ack: cover property (rise && bitn == 4'h9 && sda_oe);
    c_nack: cover property (rise && bitn == 4'h9 && !sda_oe);
    c_pd: cover property ($rose(power_down));
    c_fast: cover property ($rose(fast_mode));
endmodule

bind lhr_readout lhr_readout_checker i_lhr_readout_checker (
    .clk(clk), .reset(reset), .scl(scl), .sda_in(sda_in),
    .addr_jumper(addr_jumper), .field_ut(field_ut), .sda_out(sda_out),
    .sda_oe(sda_oe), .power_down(power_down), .fast_mode(fast_mode)
);

// *** tb/lhr_host.sv ***
`timescale 1ns/100ps
module lhr_host #(
    parameter int PWRUP_CYC = 75_001
) (
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic sda_pull
);
    initial
    begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic power_wait();
        cyc(PWRUP_CYC);
    endtask
    // Low for 5 cycles, high for 3: the device answers 3 to 4 cycles
    // after the fall, so the line is settled well before the rise.
    task automatic bit_io(input logic b, output logic r);
        @(posedge clk);
        scl <= 1'b0;
        cyc(2);
        sda_pull <= !b;
        cyc(3);
        scl <= 1'b1;
        cyc(2);
        @(negedge clk);
        r = sda;
    endtask
    task automatic cond(input logic s);
        @(posedge clk);
        scl <= 1'b0;
        cyc(2);
        sda_pull <= !s;
        cyc(3);
        scl <= 1'b1;
        cyc(4);
        sda_pull <= s;
        cyc(4);
    endtask
    task automatic put(input logic [7:0] b, inout logic ok);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(b[i], r);
        bit_io(1'b1, r);
        ok = ok && !r;
    endtask
    task automatic get(output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(1'b1, r);
            b[i] = r;
        end
        bit_io(1'b1, r);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] idx,
        input logic [7:0] d, output logic ok);
        ok = 1'b1;
        cond(1'b1);
        put({a, 1'b0}, ok);
        put(idx, ok);
        put(d, ok);
        cond(1'b0);
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] idx,
        output logic [7:0] d, output logic ok);
        ok = 1'b1;
        cond(1'b1);
        put({a, 1'b0}, ok);
        put(idx, ok);
        cond(1'b1);
        put({a, 1'b1}, ok);
        get(d);
        cond(1'b0);
    endtask
endmodule

// *** tb/tb_lhr_readout.sv ***
`timescale 1ns/100ps
module tb_lhr_readout;
    typedef struct packed {
        logic [1:0] rng;
        logic pol;
        logic [17:0] fld;
        logic [9:0] code;
    } lhr_row_t;
    localparam int WAIT_F = 2 * lhr_pkg::CONV_FAST_CYCLES + 100;
    localparam int WAIT_S = 2 * lhr_pkg::CONV_SLOW_CYCLES + 100;
    lhr_row_t rows [9] = '{
        '{2'h0, 1'b0, 18'h00000, 10'h1FF}, '{2'h0, 1'b0, 18'h33CB0, 10'h000},
        '{2'h0, 1'b0, 18'h0C3B4, 10'h3FF}, '{2'h1, 1'b0, 18'h3B1E0, 10'h067},
        '{2'h1, 1'b1, 18'h3B1E0, 10'h397}, '{2'h2, 1'b0, 18'h0186A, 10'h2FE},
        '{2'h3, 1'b0, 18'h3DB7A, 10'h100}, '{2'h2, 1'b0, 18'h1FFFF, 10'h3FF},
        '{2'h2, 1'b1, 18'h186A0, 10'h000}};
    logic clk;
    logic reset;
    logic addr_jumper;
    logic signed [17:0] field_ut;
    logic scl;
    logic pull;
    wire sda_w;
    logic sda_out;
    logic sda_oe;
    logic power_down;
    logic fast_mode;
    int error_cnt;
    int n_compared;
    logic [7:0] d;
    logic ok;
    // Pull-up: the wire is low whenever either party pulls it.
    assign sda_w = !(pull || sda_oe);
    lhr_readout i_lhr_readout (.clk(clk), .reset(reset), .scl(scl),
        .sda_in(sda_w), .addr_jumper(addr_jumper), .field_ut(field_ut),
        .sda_out(sda_out), .sda_oe(sda_oe), .power_down(power_down),
        .fast_mode(fast_mode));
    // The power-up wait is shortened so the run stays short.
    lhr_host #(.PWRUP_CYC(1000)) i_lhr_host (.clk(clk), .sda(sda_w),
        .scl(scl), .sda_pull(pull));
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic chk8(input string nm, input logic [7:0] e,
        input logic [7:0] g);
        n_compared++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk1(input string nm, input logic e, input logic g);
        chk8(nm, {7'h00, e}, {7'h00, g});
    endtask
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic rd8(input logic [7:0] idx);
        i_lhr_host.rd(lhr_pkg::ADDR_PIN_LOW, idx, d, ok);
        chk1("read_ack", 1'b1, ok);
    endtask
    task automatic wr8(input logic [7:0] idx, input logic [7:0] v);
        i_lhr_host.wr(lhr_pkg::ADDR_PIN_LOW, idx, v, ok);
        chk1("write_ack", 1'b1, ok);
    endtask
    initial
    begin
        repeat (100000) @(posedge clk);
        error_cnt++;
        $display("[FAIL] cycle_limit expected finish seen timeout");
        test_done();
    end
    initial
    begin
        reset = 1'b1;
        addr_jumper = 1'b0;
        field_ut = 18'h00000;
        error_cnt = 0;
        n_compared = 0;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        i_lhr_host.power_wait();
        // No configuration is written first, so the defaults must hold.
        rd8(lhr_pkg::REG_FIELD_CODE_HIGH_STATUS);
        // The first conversion runs right after reset, so the flag is set.
        chk8("status", 8'h0D, d);
        rd8(lhr_pkg::REG_SENSOR_CONFIG);
        chk8("config", 8'h00, d);
        rd8(lhr_pkg::REG_RANGE_SELECT);
        chk8("range", 8'h00, d);
        $display("test reset done");
        foreach (rows[i])
        begin
            field_ut <= rows[i].fld;
            wr8(lhr_pkg::REG_RANGE_SELECT, {6'h00, rows[i].rng});
            wr8(lhr_pkg::REG_SENSOR_CONFIG,
                {5'h01, 1'b0, rows[i].pol, 1'b0});
            repeat (WAIT_F) @(posedge clk);
            rd8(lhr_pkg::REG_FIELD_CODE_LOW);
            chk8("code_low", rows[i].code[7:0], d);
            rd8(lhr_pkg::REG_FIELD_CODE_HIGH_STATUS);
            chk8("code_high", {4'h0, ^rows[i].code, 1'b1,
                rows[i].code[9:8]}, d);
            chk1("fast_mode", 1'b1, fast_mode);
        end
        $display("test table done");
        wr8(lhr_pkg::REG_FIELD_CODE_LOW, 8'hAA);
        rd8(lhr_pkg::REG_FIELD_CODE_LOW);
        chk8("ro_write", 8'h00, d);
        rd8(8'h05);
        chk8("unmapped", 8'h00, d);
        wr8(lhr_pkg::REG_RANGE_SELECT, 8'hFF);
        rd8(lhr_pkg::REG_RANGE_SELECT);
        chk8("range_bits", 8'h03, d);
        $display("test refuse done");
        wr8(lhr_pkg::REG_SENSOR_CONFIG, 8'h09);
        chk1("power_down", 1'b1, power_down);
        repeat (WAIT_F) @(posedge clk);
        field_ut <= 18'h00000;
        repeat (WAIT_F) @(posedge clk);
        rd8(lhr_pkg::REG_FIELD_CODE_LOW);
        chk8("held_low", 8'h00, d);
        rd8(lhr_pkg::REG_FIELD_CODE_HIGH_STATUS);
        rd8(lhr_pkg::REG_FIELD_CODE_HIGH_STATUS);
        chk8("done_clear", 8'h00, d);
        wr8(lhr_pkg::REG_SENSOR_CONFIG, 8'h00);
        chk1("power_up", 1'b0, power_down);
        chk1("slow_mode", 1'b0, fast_mode);
        repeat (WAIT_S) @(posedge clk);
        rd8(lhr_pkg::REG_FIELD_CODE_LOW);
        chk8("slow_low", 8'hFF, d);
        $display("test power done");
        addr_jumper <= 1'b1;
        repeat (4) @(posedge clk);
        i_lhr_host.rd(lhr_pkg::ADDR_PIN_LOW, lhr_pkg::REG_SENSOR_CONFIG,
            d, ok);
        chk1("ack_low_addr", 1'b0, ok);
        i_lhr_host.wr(lhr_pkg::ADDR_PIN_HIGH, lhr_pkg::REG_SENSOR_CONFIG,
            8'hF4, ok);
        i_lhr_host.rd(lhr_pkg::ADDR_PIN_HIGH, lhr_pkg::REG_SENSOR_CONFIG,
            d, ok);
        chk1("ack_high_addr", 1'b1, ok);
        chk8("config_all", 8'hF4, d);
        $display("test address done");
        test_done();
    end
endmodule
